// ---- core/pmc_pkg.sv ----
package pmc_pkg;

  // ==========================================================================
  // register map (byte addresses)
  localparam logic [11:0] ADDR_MODE_CTRL = 12'h000;
  localparam logic [11:0] ADDR_PORTG_DATA = 12'h004;
  localparam logic [11:0] ADDR_IRQ_CTRL = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00C;
  localparam logic [11:0] ADDR_OPTION = 12'h010;

  // ==========================================================================
  // mode control fields
  localparam int BIT_LOW_OSC_ON = 7;
  localparam int BIT_FAST_OSC_ON = 6;
  localparam int BIT_DUAL_CLOCK_ENABLE = 5;
  localparam int BIT_CORE_CLOCK_SELECT = 4;
  localparam logic [7:0] MODE_CTRL_RESET = 8'h40;
  localparam logic [7:0] MODE_CTRL_WMASK = 8'hF7;
  // the only accepted upper nibbles, each keeping a clock on the core
  localparam logic [3:0] UPPER_HIGH = 4'h4;
  localparam logic [3:0] UPPER_HIGH_DUAL = 4'hC;
  localparam logic [3:0] UPPER_DUAL = 4'hE;
  localparam logic [3:0] UPPER_DUAL_LOW = 4'hF;
  localparam logic [3:0] UPPER_LOW = 4'hB;
  localparam logic [2:0] WINDOW_4K = 3'h0;
  localparam logic [2:0] WINDOW_MAX = 3'h4;
  localparam int TAP_BASE = 12;

  // port g and control bit positions
  localparam int BIT_HALT = 7;
  localparam int BIT_IDLE = 6;
  localparam int BIT_TICK_EN = 0;
  localparam int BIT_TICK_PEND = 1;
  localparam int BIT_HALT_DISABLE = 0;
  localparam int BIT_CLOCK_DELAY = 1;

  // ==========================================================================
  // timing
  localparam logic [2:0] INSTR_DIV_LAST = 3'h4;
  localparam logic [16:0] WAKE_LOAD = 17'h00100;
  localparam logic [16:0] ILLEGAL_LOAD = 17'h000F0;
  localparam logic [16:0] TIMER_ZERO = 17'h00000;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {
    PMC_RUN = 2'b00,
    PMC_IDLE = 2'b01,
    PMC_WAKE = 2'b11,
    PMC_HALT = 2'b10
  } pmc_state_t;

  typedef enum logic [1:0] {
    PMC_SPEED_HIGH = 2'b00,
    PMC_SPEED_DUAL = 2'b01,
    PMC_SPEED_LOW = 2'b10
  } pmc_speed_t;

  typedef struct packed {
    logic core_clock_en;
    logic fast_osc_en;
    logic low_osc_en;
    logic timer_on_low;
    logic core_on_low;
    logic internal_reset;
    logic tick_irq;
  } pmc_ctrl_t;

endpackage

// ---- core/pmc_ctrl.sv ----
// Added by the designer: the address map and the APB register port.
`timescale 1ns/100ps

// How it works
// - reset always returns to high-speed mode, core and timer on fast clock
// - high-speed reachable only from dual-clock or reset, never from low-speed
// - writing 1 to port g bit 7 enters halt
// - high-speed halt stops core clock and fast oscillator
// - low reset pin leaves halt and reinitialises, restarting at address zero
// - wake-up from halt always adds start-up delay regardless of delay option
// - halt entry loads timer with 256; after wake-up it counts per instruction cycle, then releases
// - start-up delay counts only while fast oscillator amplitude is qualified
// - halt-disable option ignores every software halt request
// - setting port g bit 6 enters idle
// - high-speed idle keeps fast oscillator and timer running, core stopped
// - idle window selects 4k, 8k, 16k, 32k or 64k cycles
// - idle timer counts continuously whether running or idle
// - selected tap toggle sets pending flag, irq if enabled, ends idle
// - idle exit with irq: finish current instruction, then service interrupt
// - reset or wake-up ends idle; reset selects 4,096-cycle window
// - timer not software controllable or visible; reset value undefined
// - tick interrupt requested only when enable bit is set
// - mode control bits 7..4 and window 2..0, reset value hex 40
// - dual/core select decode 00 high, 10 dual, 11 low, 01 forced low
// - illegal upper mode bits trigger automatic internal reset
// - internal reset presets timer, lasting 240 to 256 instruction cycles
module pmc_ctrl (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins and events
  input wire logic wakeup_event,
  input wire logic fast_osc_qualified,
  input wire logic instr_complete,
  // control outputs
  output pmc_pkg::pmc_ctrl_t ctrl,
  output logic [1:0] speed_mode,
  output logic [1:0] power_state
);

  // ==========================================================================
  // pin synchronisers
  logic [1:0] wake_sync;
  logic [1:0] qual_sync;
  logic wake_prev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_sync <= 2'h0;
      qual_sync <= 2'h0;
      wake_prev <= 1'b0;
    end else begin
      wake_sync <= {wake_sync[0], wakeup_event};
      qual_sync <= {qual_sync[0], fast_osc_qualified};
      wake_prev <= wake_sync[1];
    end
  end

  wire wake_rise = wake_sync[1] & ~wake_prev;
  wire osc_ok = qual_sync[1];

  // ==========================================================================
  // registers
  logic [7:0] power_mode_control_reg;
  logic idle_tick_irq_enable;
  logic idle_tick_pending;
  logic halt_disable;
  logic clock_delay_option;
  pmc_pkg::pmc_state_t state;
  logic [16:0] idle_interval_timer;
  logic [2:0] instr_div;
  logic tap_prev;
  logic int_reset;
  logic irq_hold;

  // ==========================================================================
  // apb decode
  wire wr = psel & penable & pwrite;
  wire rd_any = psel & penable & ~pwrite;
  wire hit_mode = paddr == pmc_pkg::ADDR_MODE_CTRL;
  wire hit_portg = paddr == pmc_pkg::ADDR_PORTG_DATA;
  wire hit_irq = paddr == pmc_pkg::ADDR_IRQ_CTRL;
  wire hit_stat = paddr == pmc_pkg::ADDR_STATUS;
  wire hit_opt = paddr == pmc_pkg::ADDR_OPTION;
  wire hit_any = hit_mode | hit_portg | hit_irq | hit_stat | hit_opt;
  wire [7:0] wdata8 = pwdata[7:0];

  wire wr_mode = wr & hit_mode;
  wire wr_irq = wr & hit_irq;
  wire wr_opt = wr & hit_opt;
  wire halt_req = wr & hit_portg & wdata8[pmc_pkg::BIT_HALT];
  wire idle_req = wr & hit_portg & wdata8[pmc_pkg::BIT_IDLE];
  wire halt_go = halt_req & ~halt_disable;

  // ==========================================================================
  // mode decode
  wire [7:0] next_mode_val = wdata8 & pmc_pkg::MODE_CTRL_WMASK;
  wire [3:0] upper = next_mode_val[pmc_pkg::BIT_LOW_OSC_ON -: 4];
  // legal upper nibbles: high, high/dual, dual, dual/low, low
  wire upper_legal = (upper == pmc_pkg::UPPER_HIGH) |
                     (upper == pmc_pkg::UPPER_HIGH_DUAL) |
                     (upper == pmc_pkg::UPPER_DUAL) |
                     (upper == pmc_pkg::UPPER_DUAL_LOW) |
                     (upper == pmc_pkg::UPPER_LOW);
  wire illegal_write = wr_mode & ~upper_legal;
  // low-speed may not jump straight to high-speed
  wire cur_low = power_mode_control_reg[pmc_pkg::BIT_CORE_CLOCK_SELECT] &
                 power_mode_control_reg[pmc_pkg::BIT_DUAL_CLOCK_ENABLE];
  wire to_high = ~next_mode_val[pmc_pkg::BIT_DUAL_CLOCK_ENABLE] &
                 ~next_mode_val[pmc_pkg::BIT_CORE_CLOCK_SELECT];
  wire blocked_write = wr_mode & upper_legal & cur_low & to_high;

  wire dual_clock_enable = power_mode_control_reg[pmc_pkg::BIT_DUAL_CLOCK_ENABLE];
  wire ccsel = power_mode_control_reg[pmc_pkg::BIT_CORE_CLOCK_SELECT];
  // 01 is treated as low speed
  wire core_low = ccsel;
  wire timer_low = dual_clock_enable | ccsel;
  wire [1:0] next_speed = core_low ? pmc_pkg::PMC_SPEED_LOW :
                          (dual_clock_enable ? pmc_pkg::PMC_SPEED_DUAL : pmc_pkg::PMC_SPEED_HIGH);

  // ==========================================================================
  // idle interval timer
  wire [2:0] win = power_mode_control_reg[2:0];
  wire [2:0] win_sel = (win > pmc_pkg::WINDOW_MAX) ? pmc_pkg::WINDOW_MAX : win;
  wire instr_tick = instr_div == pmc_pkg::INSTR_DIV_LAST;
  wire in_wake = state == pmc_pkg::PMC_WAKE;
  wire in_halt = state == pmc_pkg::PMC_HALT;
  // frozen in halt; during start-up only while oscillator qualified
  wire timer_step = instr_tick & ~in_halt & (~in_wake | osc_ok);
  wire [16:0] timer_dec = idle_interval_timer - 17'h00001;
  wire [4:0] taps = idle_interval_timer[pmc_pkg::TAP_BASE +: 5];
  wire tap_now = taps[win_sel];
  wire tap_toggle = (tap_now != tap_prev) & ~in_wake & ~int_reset;
  wire wake_done = in_wake & timer_step & (idle_interval_timer == pmc_pkg::TIMER_ZERO);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_div <= 3'h0;
    end else begin
      instr_div <= instr_tick ? 3'h0 : instr_div + 3'h1;
    end
  end

  // timer carries no reset; its value after reset is arbitrary
  always_ff @(posedge pclk) begin
    if (halt_go && state == pmc_pkg::PMC_RUN) begin
      idle_interval_timer <= pmc_pkg::WAKE_LOAD;
    end else if (illegal_write) begin
      idle_interval_timer <= pmc_pkg::ILLEGAL_LOAD;
    end else if (timer_step) begin
      idle_interval_timer <= timer_dec;
    end
    tap_prev <= tap_now;
  end

  // ==========================================================================
  // internal reset from illegal mode write, ends when timer runs out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_reset <= 1'b0;
    end else if (illegal_write) begin
      int_reset <= 1'b1;
    end else if (timer_step && idle_interval_timer == pmc_pkg::TIMER_ZERO) begin
      int_reset <= 1'b0;
    end
  end

  // ==========================================================================
  // software registers
  // an illegal nibble never lands: the internal reset reloads the reset value instead
  wire mode_take = wr_mode & upper_legal & ~blocked_write;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_mode_control_reg <= pmc_pkg::MODE_CTRL_RESET;
    end else if (int_reset) begin
      power_mode_control_reg <= pmc_pkg::MODE_CTRL_RESET;
    end else if (mode_take) begin
      power_mode_control_reg <= next_mode_val;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_tick_irq_enable <= 1'b0;
    end else if (int_reset) begin
      idle_tick_irq_enable <= 1'b0;
    end else if (wr_irq) begin
      idle_tick_irq_enable <= wdata8[pmc_pkg::BIT_TICK_EN];
    end
  end

  // options survive the internal reset; only the pin or an option register write clears them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_disable <= 1'b0;
      clock_delay_option <= 1'b0;
    end else if (wr_opt) begin
      halt_disable <= wdata8[pmc_pkg::BIT_HALT_DISABLE];
      clock_delay_option <= wdata8[pmc_pkg::BIT_CLOCK_DELAY];
    end
  end

  // pending: hardware set wins over software clear
  wire clr_pend = wr_irq & ~wdata8[pmc_pkg::BIT_TICK_PEND];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_tick_pending <= 1'b0;
    end else if (tap_toggle) begin
      idle_tick_pending <= 1'b1;
    end else if (clr_pend || int_reset) begin
      idle_tick_pending <= 1'b0;
    end
  end

  // ==========================================================================
  // power state machine
  pmc_pkg::pmc_state_t next_state;
  always_comb begin
    next_state = state;
    unique case (state)
      pmc_pkg::PMC_RUN: begin
        if (halt_go) begin
          next_state = pmc_pkg::PMC_HALT;
        end else if (idle_req) begin
          next_state = pmc_pkg::PMC_IDLE;
        end
      end
      pmc_pkg::PMC_IDLE: begin
        if (tap_toggle || wake_rise) begin
          next_state = pmc_pkg::PMC_RUN;
        end
      end
      pmc_pkg::PMC_HALT: begin
        // delay inserted whatever the delay option says
        if (wake_rise) begin
          next_state = pmc_pkg::PMC_WAKE;
        end
      end
      pmc_pkg::PMC_WAKE: begin
        if (wake_done) begin
          next_state = pmc_pkg::PMC_RUN;
        end
      end
    endcase
    if (int_reset) begin
      next_state = pmc_pkg::PMC_RUN;
    end
  end

  // async pin reset drops halt/idle back to run at address zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= pmc_pkg::PMC_RUN;
    end else begin
      state <= next_state;
    end
  end

  // irq held from idle exit until the instruction in flight completes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_hold <= 1'b0;
    end else if (state == pmc_pkg::PMC_IDLE && tap_toggle) begin
      irq_hold <= 1'b1;
    end else if (instr_complete) begin
      irq_hold <= 1'b0;
    end
  end

  // ==========================================================================
  // outputs
  wire stopped = (next_state != pmc_pkg::PMC_RUN) | int_reset;
  wire halted = next_state == pmc_pkg::PMC_HALT;
  pmc_pkg::pmc_ctrl_t next_ctrl;
  always_comb begin
    next_ctrl.core_clock_en = ~stopped;
    next_ctrl.fast_osc_en = power_mode_control_reg[pmc_pkg::BIT_FAST_OSC_ON] &
                            ~(halted & ~dual_clock_enable & ~ccsel);
    next_ctrl.low_osc_en = power_mode_control_reg[pmc_pkg::BIT_LOW_OSC_ON];
    next_ctrl.timer_on_low = timer_low;
    next_ctrl.core_on_low = core_low;
    next_ctrl.internal_reset = int_reset | illegal_write;
    next_ctrl.tick_irq = idle_tick_pending & idle_tick_irq_enable & ~irq_hold;
  end

  wire [31:0] rd_val = hit_mode ? {24'h000000, power_mode_control_reg} :
                       hit_irq ? {30'h00000000, idle_tick_pending, idle_tick_irq_enable} :
                       hit_stat ? {28'h0000000, state, next_speed} :
                       hit_opt ? {30'h00000000, clock_delay_option, halt_disable} :
                       32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= '0;
      speed_mode <= pmc_pkg::PMC_SPEED_HIGH;
      power_state <= pmc_pkg::PMC_RUN;
    end else begin
      ctrl <= next_ctrl;
      speed_mode <= next_speed;
      power_state <= next_state;
    end
  end

  // zero wait states: ready is launched by the setup cycle itself
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit_any;
      prdata <= (psel & ~penable & ~pwrite) ? rd_val : prdata;
    end
  end

  wire unused_ok = rd_any;

endmodule

// ---- tb/pmc_ctrl_props.sv ----
`timescale 1ns/100ps
// ========================================
// port checks for the power-mode sequencer
module pmc_chk (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // sequencer
  input wire logic fast_osc_qualified,
  input wire logic instr_complete,
  input wire pmc_pkg::pmc_ctrl_t ctrl,
  input wire logic [1:0] speed_mode,
  input wire logic [1:0] power_state
);
  logic [11:0] wake_cnt;
  logic [11:0] irst_cnt;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // counters bound long phases without huge repetitions
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_cnt <= 12'h000;
      irst_cnt <= 12'h000;
    end else begin
      wake_cnt <= (power_state == 2'b11) ? wake_cnt + 12'h001 : 12'h000;
      irst_cnt <= ctrl.internal_reset ? irst_cnt + 12'h001 : 12'h000;
    end
  end
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_halt_clocks_off: assert property (power_state == 2'b10 |-> !ctrl.core_clock_en && !ctrl.fast_osc_en)
    else $error("clock running in halt");
  a_idle_osc_on: assert property (power_state == 2'b01 |-> ctrl.fast_osc_en && !ctrl.core_clock_en)
    else $error("wrong clocks in idle");
  a_no_low_high: assert property (speed_mode == 2'b10 && !ctrl.internal_reset |=> speed_mode != 2'b00 || ctrl.internal_reset)
    else $error("low speed went straight to high");
  a_wake_unqual: assert property ((power_state == 2'b11 && !fast_osc_qualified)[*4] |=> power_state == 2'b11)
    else $error("wake ended without amplitude");
  a_wake_delay: assert property (wake_cnt != 12'h000 && power_state != 2'b11 |-> wake_cnt >= 12'h4FC)
    else $error("start-up delay too short");
  a_ireset_len: assert property (irst_cnt != 12'h000 && !ctrl.internal_reset |-> irst_cnt >= 12'h4AC && irst_cnt <= 12'h505)
    else $error("internal reset length wrong");
  a_idle_exit_mask: assert property (power_state == 2'b01 ##1 power_state == 2'b00 ##1 !instr_complete |=> !ctrl.tick_irq)
    else $error("tick irq before instruction done");
endmodule

bind pmc_ctrl pmc_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .fast_osc_qualified(fast_osc_qualified),
  .instr_complete(instr_complete), .ctrl(ctrl), .speed_mode(speed_mode),
  .power_state(power_state));

// ---- tb/tb.sv ----
`timescale 1ns/100ps
// ========================================
// register-level bench
module tb;
  localparam logic [11:0] A_MC = pmc_pkg::ADDR_MODE_CTRL;
  localparam logic [11:0] A_PG = pmc_pkg::ADDR_PORTG_DATA;
  localparam logic [11:0] A_IRQ = pmc_pkg::ADDR_IRQ_CTRL;
  localparam logic [11:0] A_ST = pmc_pkg::ADDR_STATUS;
  localparam logic [11:0] A_OPT = pmc_pkg::ADDR_OPTION;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic wakeup_event, fast_osc_qualified, instr_complete;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  pmc_pkg::pmc_ctrl_t ctrl;
  logic [1:0] speed_mode, power_state;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  int n, t0;
  logic [7:0] mw [9] = '{8'hC0, 8'hE0, 8'hF0, 8'hB0, 8'hC0, 8'hF0, 8'hE0, 8'hC0, 8'h40};
  logic [7:0] mr [9] = '{8'hC0, 8'hE0, 8'hF0, 8'hB0, 8'hB0, 8'hF0, 8'hE0, 8'hC0, 8'h40};
  logic [1:0] ms [9] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h2, 2'h2, 2'h1, 2'h0, 2'h0};

  pmc_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wakeup_event(wakeup_event), .fast_osc_qualified(fast_osc_qualified),
    .instr_complete(instr_complete), .ctrl(ctrl), .speed_mode(speed_mode),
    .power_state(power_state));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer; starts on a fresh edge so releases never collide
  // a ready that never comes is ended by the hang guard, not here
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    check(r, exp);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task automatic wait_st(input logic [1:0] s, input int lim);
    n = 0;
    while (power_state !== s && n < lim) begin
      n++;
      @(posedge pclk);
    end
  endtask
  task automatic pulse_done();
    instr_complete <= 1'b1;
    @(posedge pclk);
    instr_complete <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  task automatic close_out();
    if (n_mismatch == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // hang guard: the whole run needs about 46k cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      n_mismatch++;
      close_out();
    end
  end

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, wakeup_event, instr_complete} = 5'h00;
    fast_osc_qualified = 1'b1;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    check({30'h0, ctrl.core_clock_en, ctrl.fast_osc_en}, 32'h3);
    rd(A_MC, 32'h40);
    rd(A_ST, 32'h0);
    xfer(12'h014, 1'b0, 32'h0);
    check(r, 32'h0);
    check({31'h0, e}, 32'h1);
    wr(A_MC, 32'h4F);
    rd(A_MC, 32'h47);
    for (int i = 0; i < 9; i++) begin
      wr(A_MC, {24'h0, mw[i]});
      rd(A_MC, {24'h0, mr[i]});
      check({30'h0, speed_mode}, {30'h0, ms[i]});
      check({28'h0, ctrl.low_osc_en, ctrl.fast_osc_en, ctrl.timer_on_low, ctrl.core_on_low}, {28'h0, mr[i][7:4]});
    end
    wr(A_MC, 32'h80);
    repeat (3) @(posedge pclk);
    n = 0;
    while (ctrl.internal_reset === 1'b1 && n < 2000) begin
      n++;
      @(posedge pclk);
    end
    check({31'h0, n >= 1190 && n <= 1285}, 32'h1);
    rd(A_MC, 32'h40);
    wr(A_OPT, 32'h1);
    wr(A_PG, 32'h80);
    repeat (20) @(posedge pclk);
    check({30'h0, power_state}, 32'h0);
    wr(A_OPT, 32'h0);
    wr(A_MC, 32'h42);
    wr(A_PG, 32'h80);
    wait_st(2'b10, 20);
    check({30'h0, power_state}, 32'h2);
    check({30'h0, ctrl.core_clock_en, ctrl.fast_osc_en}, 32'h0);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_ST, 32'h0);
    rd(A_MC, 32'h40);
    wr(A_PG, 32'h80);
    wait_st(2'b10, 20);
    fast_osc_qualified <= 1'b0;
    wakeup_event <= 1'b1;
    wait_st(2'b11, 20);
    check({30'h0, power_state}, 32'h3);
    repeat (2000) @(posedge pclk);
    check({30'h0, power_state}, 32'h3);
    fast_osc_qualified <= 1'b1;
    wakeup_event <= 1'b0;
    wait_st(2'b00, 2000);
    check({31'h0, n >= 1270 && n <= 1295}, 32'h1);
    wr(A_IRQ, 32'h1);
    wr(A_PG, 32'h40);
    wait_st(2'b01, 20);
    check({30'h0, power_state}, 32'h1);
    check({30'h0, ctrl.core_clock_en, ctrl.fast_osc_en}, 32'h1);
    wait_st(2'b00, 25000);
    t0 = cyc;
    check({31'h0, ctrl.tick_irq}, 32'h0);
    pulse_done();
    check({31'h0, ctrl.tick_irq}, 32'h1);
    rd(A_IRQ, 32'h3);
    wr(A_IRQ, 32'h1);
    wr(A_PG, 32'h40);
    wait_st(2'b01, 20);
    wait_st(2'b00, 25000);
    check({31'h0, cyc - t0 >= 20470 && cyc - t0 <= 20490}, 32'h1);
    wr(A_IRQ, 32'h2);
    pulse_done();
    check({31'h0, ctrl.tick_irq}, 32'h0);
    wr(A_IRQ, 32'h3);
    repeat (3) @(posedge pclk);
    check({31'h0, ctrl.tick_irq}, 32'h1);
    wr(A_IRQ, 32'h2);
    wr(A_MC, 32'h41);
    wr(A_IRQ, 32'h1);
    rd(A_IRQ, 32'h1);
    check({31'h0, ctrl.tick_irq}, 32'h0);
    wr(A_PG, 32'h40);
    wait_st(2'b01, 20);
    check({30'h0, power_state}, 32'h1);
    wakeup_event <= 1'b1;
    wait_st(2'b00, 20);
    check({30'h0, power_state}, 32'h0);
    repeat (3) @(posedge pclk);
    check({31'h0, ctrl.tick_irq}, 32'h0);
    wakeup_event <= 1'b0;
    close_out();
  end
endmodule
